// ==== qmac_core.sv ====
`timescale 1ns/10ps
// Operation
// R1: Continuously compute 8-bit ADC metric: 0 above threshold, 255 at underflow.
// R2: ADC metric is readable as a variable output and feeds the status PWM.
// R3: Four adaption metrics: 0 below threshold, 255 at fault, proportional between.
// R4: Adaption metric is the sum of the four metrics, readable as output.
// R5: Adaption fault raised when summed adaption metric reaches 255.
// R6: Status output is PWM whose duty follows enabled monitor outputs.
// R7: Polarity setting chooses rising or falling duty with metric.
// R8: Mode setting chooses linear or logarithmic duty law; code uses a square law for the log mode.
// R9: Each monitor has its own enable; disabled monitors have no effect.
// R10: Outside party pulls the calibration pin low and holds it.
// R11: While pin low, device adapts all signal path parameters.
// R12: Calibration accepts varying rate and reversing input; no direction check.
// R13: Pin release immediately requests store of all parameters to EEPROM.
// R14: Software may preload parameters, let them adapt, then store them.
// R15: Software auto adaption enable starts adaption of all parameters.
// R16: Tolerance code 0x00 is the tightest gain and offset tolerance.
// R17: Explicit write request stores all calibrated parameters to EEPROM.
// R18: Adaption fault latches fault output and stops adaption until cleared.
// R19: Underflow level programmable 10% to 100%, default 10%.
// R20: Latched faults cleared by restart or status register write; code also clears them on i_ee_params_valid.
// R21: Adaption sum saturates at 255 instead of wrapping.
// R22: Status PWM has a fixed 256-step period, duty loaded once per period.
module qmac_core
  import qmac_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  // ADC monitor
  input  wire logic          i_adc_mon_en,
  input  wire logic [MW-1:0] i_adc_level,
  input  wire logic [MW-1:0] i_adc_quality_thr,
  input  wire logic [MW-1:0] i_adc_underflow_lvl,
  input  wire logic          i_adc_underflow_set,
  // Adaption monitor
  input  wire logic          i_adapt_mon_en,
  input  wire logic [MW-1:0] i_adapt_sin_offs,
  input  wire logic [MW-1:0] i_adapt_cos_offs,
  input  wire logic [MW-1:0] i_adapt_gain,
  input  wire logic [MW-1:0] i_adapt_phase,
  input  wire logic [MW-1:0] i_adapt_quality_thr,
  input  wire logic [MW-1:0] i_adapt_fault_lvl,
  // Status PWM setup
  input  wire logic          i_pwm_invert,
  input  wire logic          i_pwm_log,
  // Calibration control
  input  wire logic          i_calibration_request_pin,
  input  wire logic          i_auto_adapt_en,
  input  wire logic [MW-1:0] i_gain_tol,
  input  wire logic [MW-1:0] i_offs_tol,
  input  wire logic          i_ee_write_req,
  input  wire logic          i_ee_params_valid,
  input  wire logic          i_fault_clear,
  // Results
  output logic [MW-1:0]      o_adc_quality_metric,
  output logic [MW-1:0]      o_adaption_quality_metric,
  output logic               o_status_pwm,
  output logic               o_adapt_fault,
  output logic               o_adapt_run,
  output logic               o_ee_store,
  output logic [MW-1:0]      o_gain_tol,
  output logic [MW-1:0]      o_offs_tol
);

  // Metric from position of v between lo and hi, scaled to 0..255
  function automatic logic [MW-1:0] qmac_scale(input logic [MW-1:0] v,
                                               input logic [MW-1:0] lo,
                                               input logic [MW-1:0] hi);
    logic [15:0] num;
    logic [15:0] q;
    num = 16'({8'h00, v - lo}) * 16'(METRIC_MAX);
    q   = (hi > lo) ? num / 16'({8'h00, hi - lo}) : 16'(METRIC_MAX);
    return (q > 16'(METRIC_MAX)) ? METRIC_MAX : q[MW-1:0];
  endfunction

  function automatic logic [MW-1:0] qmac_adapt(input logic [MW-1:0] v,
                                               input logic [MW-1:0] thr,
                                               input logic [MW-1:0] flt);
    if (v < thr)
      return METRIC_MIN;
    else if (v >= flt)
      return METRIC_MAX;
    else
      return qmac_scale(v, thr, flt);
  endfunction

  // ADC monitor
  logic [MW-1:0] adc_m;
  logic [MW-1:0] next_adc_m;
  logic [MW-1:0] ufl;

  always_comb begin
    // Underflow point is the full-scale end of the metric
    ufl = i_adc_underflow_set ? i_adc_underflow_lvl : UFL_DEFAULT; // [R19]
    if (!i_adc_mon_en)
      next_adc_m = METRIC_MIN; // [R9]
    else if (i_adc_level > i_adc_quality_thr)
      next_adc_m = METRIC_MIN; // [R1]
    else if (i_adc_level <= ufl)
      next_adc_m = METRIC_MAX; // [R1]
    else
      next_adc_m = METRIC_MAX - qmac_scale(i_adc_level, ufl, i_adc_quality_thr); // [R1]
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      adc_m <= METRIC_MIN;
    else
      adc_m <= next_adc_m;
  end

  // Adaption monitor, four parameters against shared limits
  logic [MW-1:0] adapt_m;
  logic [MW-1:0] next_adapt_m;
  logic [MW-1:0] each_m [4];
  logic [9:0]    sum;

  always_comb begin
    each_m[0] = qmac_adapt(i_adapt_sin_offs, i_adapt_quality_thr, i_adapt_fault_lvl); // [R3]
    each_m[1] = qmac_adapt(i_adapt_cos_offs, i_adapt_quality_thr, i_adapt_fault_lvl); // [R3]
    each_m[2] = qmac_adapt(i_adapt_gain, i_adapt_quality_thr, i_adapt_fault_lvl);     // [R3]
    each_m[3] = qmac_adapt(i_adapt_phase, i_adapt_quality_thr, i_adapt_fault_lvl);    // [R3]
    // Ten bits hold four full-scale terms, so the sum cannot wrap
    sum = 10'(each_m[0]) + 10'(each_m[1])
        + 10'(each_m[2]) + 10'(each_m[3]); // [R4]
    if (!i_adapt_mon_en)
      next_adapt_m = METRIC_MIN; // [R9]
    else if (sum >= SUM_MAX)
      next_adapt_m = METRIC_MAX; // [R21]
    else
      next_adapt_m = sum[MW-1:0];
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      adapt_m <= METRIC_MIN;
    else
      adapt_m <= next_adapt_m;
  end

  // Status PWM counter, free running over one period
  logic [MW-1:0] pwm_cnt;
  logic [MW-1:0] next_pwm_cnt;

  always_comb begin
    // Wraps at the period end by design
    next_pwm_cnt = pwm_cnt + 8'h01; // [R22]
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      pwm_cnt <= METRIC_MIN;
    else
      pwm_cnt <= next_pwm_cnt;
  end

  // Status PWM duty and output
  logic [MW-1:0] duty;
  logic [MW-1:0] next_duty;
  logic          pwm;
  logic          next_pwm;
  logic [MW-1:0] level;
  logic [8:0]    lvl_sum;
  logic [15:0]   sq;
  logic [15:0]   sq_top;

  always_comb begin
    // Disabled monitors read zero, so only enabled ones add in
    lvl_sum = 9'(adc_m) + 9'(adapt_m); // [R6] [R9]
    level   = lvl_sum[MW] ? METRIC_MAX : lvl_sum[MW-1:0];
    if (i_pwm_invert)
      level = METRIC_MAX - level; // [R7]
    // Square law stands in for log: cheap and perceptually close for an LED
    sq        = 16'(level) * 16'(level);
    sq_top    = sq >> LOG_SHIFT;
    next_duty = duty;
    // Duty changes only at period end, so no period is cut short
    if (pwm_cnt == PWM_LAST)
      next_duty = i_pwm_log ? sq_top[MW-1:0] : level; // [R8] [R22]
    next_pwm = (next_pwm_cnt < next_duty); // [R6]
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      duty <= METRIC_MIN;
      pwm  <= 1'b0;
    end else begin
      duty <= next_duty;
      pwm  <= next_pwm;
    end
  end

  // Adaption fault latch
  logic fault;
  logic next_fault;

  always_comb begin
    // Set wins over clear so a fault in the clear cycle is kept
    next_fault = fault;
    // Valid stored parameters clear it just as a status write does
    if (i_fault_clear || i_ee_params_valid)
      next_fault = 1'b0; // [R20]
    if (i_adapt_mon_en && next_adapt_m == METRIC_MAX)
      next_fault = 1'b1; // [R5] [R18]
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      fault <= 1'b0;
    else
      fault <= next_fault;
  end

  // Calibration sequencer
  qmac_cal_t state;
  qmac_cal_t next_state;
  logic      store;
  logic      next_store;

  always_comb begin
    next_state = state;
    next_store = 1'b0;
    // Pin low enters calibration; release goes through QMAC_STORE, which pulses the store
    unique case (state)
      QMAC_IDLE: begin
        if (!i_calibration_request_pin)
          next_state = QMAC_CAL; // [R10]
        // A store request during calibration is ignored; release stores anyway
        if (i_ee_write_req)
          next_store = 1'b1; // [R14] [R17]
      end
      QMAC_CAL: begin
        if (i_calibration_request_pin)
          next_state = QMAC_STORE; // [R13]
      end
      QMAC_STORE: begin
        next_store = 1'b1; // [R13]
        next_state = QMAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= QMAC_IDLE;
      store <= 1'b0;
    end else begin
      state <= next_state;
      store <= next_store;
    end
  end

  // Adaption run enable
  logic run;
  logic next_run;

  always_comb begin
    // No rate or direction qualifier on adaption [R12]
    next_run = (next_state == QMAC_CAL || i_auto_adapt_en) && !next_fault; // [R11] [R15] [R18]
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      run <= 1'b0;
    else
      run <= next_run;
  end

  // Tolerances: code 0x00 is tightest and passes unchanged [R16]
  logic [MW-1:0] gtol;
  logic [MW-1:0] otol;
  logic [MW-1:0] next_gtol;
  logic [MW-1:0] next_otol;

  always_comb begin
    next_gtol = i_gain_tol; // [R16]
    next_otol = i_offs_tol; // [R16]
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gtol <= TOL_TIGHT;
      otol <= TOL_TIGHT;
    end else begin
      gtol <= next_gtol;
      otol <= next_otol;
    end
  end

  // Outputs come straight from registers
  assign o_adc_quality_metric      = adc_m;   // [R2]
  assign o_adaption_quality_metric = adapt_m; // [R4]
  assign o_status_pwm              = pwm;
  assign o_adapt_fault             = fault;
  assign o_adapt_run               = run;
  assign o_ee_store                = store;
  assign o_gain_tol                = gtol;
  assign o_offs_tol                = otol;

endmodule // qmac_core

// ==== qmac_pkg.sv ====
package qmac_pkg;
  localparam int          MW          = 8;
  localparam logic [7:0]  METRIC_MIN  = 8'h00;
  localparam logic [7:0]  METRIC_MAX  = 8'hFF;
  localparam logic [9:0]  SUM_MAX     = 10'h0FF;
  localparam logic [7:0]  PWM_LAST    = 8'hFF;
  localparam logic [7:0]  UFL_DEFAULT = 8'h1A;
  localparam logic [7:0]  TOL_TIGHT   = 8'h00;
  localparam logic [3:0]  LOG_SHIFT   = 4'h8;
  typedef enum logic [1:0] {QMAC_IDLE, QMAC_CAL, QMAC_STORE} qmac_cal_t;
endpackage

// ==== qmac_checker.sv ====
`timescale 1ns/10ps
module qmac_checker
  import qmac_pkg::*;
(
  // Watched ports
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_adc_mon_en,
  input wire logic [7:0] i_adc_level,
  input wire logic [7:0] i_adc_quality_thr,
  input wire logic       i_adc_underflow_set,
  input wire logic       i_calibration_request_pin,
  input wire logic       i_fault_clear,
  input wire logic       i_ee_params_valid,
  input wire logic [7:0] o_adc_quality_metric,
  input wire logic [7:0] o_adaption_quality_metric,
  input wire logic       o_adapt_fault,
  input wire logic       o_adapt_run,
  input wire logic       o_ee_store
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence rel_s; !i_calibration_request_pin ##1 i_calibration_request_pin; endsequence
  sequence pulse_s; o_ee_store ##1 !o_ee_store; endsequence
  store_on_release_a: assert property (rel_s |=> ##1 pulse_s) else $error("no store");
  cal_run_a: assert property (!i_calibration_request_pin [*2] |-> o_adapt_run || o_adapt_fault)
    else $error("no run");
  fault_set_a: assert property (o_adaption_quality_metric == METRIC_MAX |-> o_adapt_fault)
    else $error("no fault");
  fault_hold_a: assert property (o_adapt_fault && !i_fault_clear && !i_ee_params_valid
    |=> o_adapt_fault) else $error("fault lost");
  fault_stop_a: assert property (o_adapt_fault && $past(o_adapt_fault) |-> !o_adapt_run)
    else $error("run in fault");
  adc_zero_a: assert property (i_adc_mon_en && i_adc_level > i_adc_quality_thr
    |=> o_adc_quality_metric == METRIC_MIN) else $error("adc not 0");
  adc_full_a: assert property (i_adc_mon_en && !i_adc_underflow_set && i_adc_level <=
    UFL_DEFAULT && i_adc_level <= i_adc_quality_thr |=> o_adc_quality_metric == METRIC_MAX)
    else $error("adc not full");
  adc_off_a: assert property (!i_adc_mon_en |=> o_adc_quality_metric == METRIC_MIN)
    else $error("adc off");
endmodule // qmac_checker
bind qmac_core qmac_checker u_chk (.*);

// ==== qmac_partner.sv ====
`timescale 1ns/10ps
module qmac_partner (
  // Button, EEPROM and LED side
  input  wire logic  i_clk,
  input  wire logic  i_press,
  input  wire logic  i_clr,
  input  wire logic  i_ee_store,
  input  wire logic  i_status_pwm,
  output logic       o_pin,
  output logic [7:0] o_stores = '0,
  output logic [7:0] o_lit = '0
);
  // Pull-up: released button reads high
  assign o_pin = !i_press;
  always @(posedge i_clk) begin
    if (i_ee_store) o_stores <= o_stores + 8'h01;
    o_lit <= i_clr ? 8'h00 : o_lit + {7'h00, i_status_pwm};
  end
endmodule // qmac_partner

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import qmac_pkg::*;
  logic i_clk = 0, i_reset_n = 0, press = 0, clr = 0, i_adc_underflow_set = 0, i_adc_mon_en = 0;
  logic i_adapt_mon_en = 0, i_pwm_invert = 0, i_pwm_log = 0, i_auto_adapt_en = 0;
  logic i_ee_write_req = 0, i_ee_params_valid = 0, i_fault_clear = 0;
  logic [7:0] i_adc_level = '0, i_adc_quality_thr = '0, i_adc_underflow_lvl = 8'h80, got;
  logic [7:0] i_adapt_sin_offs = '0, i_adapt_cos_offs = '0, i_adapt_gain = '0, i_adapt_phase = '0;
  logic [7:0] i_adapt_quality_thr = 8'h10, i_adapt_fault_lvl = 8'h50, i_gain_tol = '0;
  logic [7:0] i_offs_tol = '0, o_adc_quality_metric, o_adaption_quality_metric, stores, lit;
  logic [7:0] o_gain_tol, o_offs_tol, q[$];
  logic i_calibration_request_pin, o_status_pwm, o_adapt_fault, o_adapt_run, o_ee_store;
  logic [2:0] sel = '0;
  logic [31:0] rs = 32'h3E;
  int fail_count = 0, tests_run = 0, s, d, u;
  qmac_core dut (.*);
  qmac_partner pm (.i_clk, .i_press(press), .i_clr(clr), .i_ee_store(o_ee_store),
    .i_status_pwm(o_status_pwm), .o_pin(i_calibration_request_pin), .o_stores(stores), .o_lit(lit));
  initial forever #25 i_clk = ~i_clk;
  function automatic logic [7:0] nx();
    rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5; return rs[7:0];
  endfunction
  function automatic int am(logic [7:0] v);
    return v < 8'h10 ? 0 : v >= 8'h50 ? 255 : (v - 8'h10) * 255 / 64;
  endfunction
  task automatic cyc(int n); repeat (n) @(negedge i_clk); endtask
  task automatic set4(logic [7:0] v);
    {i_adapt_sin_offs, i_adapt_cos_offs, i_adapt_gain, i_adapt_phase} = {4{v}};
  endtask
  task automatic chk(logic [2:0] k, logic [7:0] v);
    q.push_back(v); sel = k; cyc(1); sel = '0;
  endtask
  // Oldest note answers the result seen now
  always @(posedge i_clk) if (sel != 0) begin
    #1;
    got = sel == 1 ? o_adc_quality_metric : sel == 2 ? o_adaption_quality_metric :
      sel == 3 ? stores : sel == 4 ? lit : sel == 5 ? o_gain_tol : sel == 7 ? o_offs_tol :
      {6'h00, o_adapt_fault, o_adapt_run};
    tests_run++;
    if (got !== q[0]) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, q[0]);
    end
    void'(q.pop_front());
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    cyc(20);
    i_reset_n = 1;
    cyc(2);
    i_adc_mon_en = 1;
    repeat (40) begin
      i_adc_level = nx();
      if (rs[8]) i_adc_level &= 8'h1F;
      i_adc_quality_thr = nx();
      i_gain_tol = nx();
      i_offs_tol = nx();
      i_adc_underflow_set = rs[9];
      u = i_adc_underflow_set ? int'(i_adc_underflow_lvl) : int'(UFL_DEFAULT);
      cyc(1);
      if (i_adc_level > i_adc_quality_thr) chk(1, 8'h00);
      else if (i_adc_level <= u) chk(1, 8'hFF);
      else chk(1, 8'(255 - (int'(i_adc_level) - u) * 255 / (int'(i_adc_quality_thr) - u)));
      chk(5, i_gain_tol);
      chk(7, i_offs_tol);
    end
    i_adc_mon_en = 0;
    i_adapt_mon_en = 1;
    repeat (40) begin
      {i_adapt_sin_offs, i_adapt_cos_offs} = {nx() & 8'h5F, nx() & 8'h5F};
      {i_adapt_gain, i_adapt_phase} = {nx() & 8'h5F, nx() & 8'h5F};
      s = am(i_adapt_sin_offs) + am(i_adapt_cos_offs) + am(i_adapt_gain) + am(i_adapt_phase);
      cyc(1);
      chk(2, s > 255 ? 8'hFF : 8'(s));
    end
    i_auto_adapt_en = 1;
    for (int k = 0; k < 2; k++) begin
      set4(8'h50);
      cyc(1);
      chk(6, 8'h02);
      set4('0);
      cyc(2);
      chk(6, 8'h02);
      {i_fault_clear, i_ee_params_valid} = k ? 2'h1 : 2'h2;
      cyc(1);
      {i_fault_clear, i_ee_params_valid} = '0;
      cyc(1);
      chk(6, 8'h01);
    end
    i_auto_adapt_en = 0;
    i_adapt_sin_offs = 8'h30;
    for (int k = 0; k < 4; k++) begin
      {i_pwm_log, i_pwm_invert} = 2'(k);
      cyc(600);
      clr = 1;
      cyc(1);
      clr = 0;
      cyc(255);
      d = k[0] ? 128 : 127;
      chk(4, k[1] ? 8'(d * d >> 8) : 8'(d));
    end
    i_adapt_mon_en = 0;
    i_ee_write_req = 1;
    cyc(1);
    i_ee_write_req = 0;
    cyc(2);
    chk(3, 8'h01);
    press = 1;
    cyc(3);
    chk(6, 8'h01);
    press = 0;
    cyc(4);
    chk(3, 8'h02);
    end_of_test();
  end
endmodule // tb_top
